// [design/tmr16_regs.svh]
// Register map, field positions and fixed counts of the 16-bit timer.
// Assumes a 16-bit plain register port with word addresses.
`ifndef TMR16_REGS_SVH
`define TMR16_REGS_SVH
`define TMR_A_CTRL_A 4'h0
`define TMR_A_CTRL_B 4'h1
`define TMR_A_COUNT 4'h2
`define TMR_A_CMP_A 4'h3
`define TMR_A_CMP_B 4'h4
`define TMR_A_CAPTURE 4'h5
`define TMR_A_FLAGS 4'h6
`define TMR_A_PIN_DIR 4'h7
`define TMR_CA_MASK 8'hF3
`define TMR_CB_MASK 8'hDF
`define TMR_CB_FILT 7
`define TMR_CB_EDGE 6
`define TMR_CB_WGMH_HI 4
`define TMR_CB_WGMH_LO 3
`define TMR_CB_CS_HI 2
`define TMR_FL_OVF 0
`define TMR_FL_MA 1
`define TMR_FL_MB 2
`define TMR_FL_CAP 3
`define TMR_BOTTOM 16'h0000
`define TMR_MAX 16'hFFFF
`define TMR_TOP8 16'h00FF
`define TMR_TOP9 16'h01FF
`define TMR_TOP10 16'h03FF
`define TMR_DIV8 10'h007
`define TMR_DIV64 10'h03F
`define TMR_DIV256 10'h0FF
`define TMR_DIV1024 10'h3FF
`define TMR_FILT_ONES 4'hF
`define TMR_FILT_ZERO 4'h0
`endif

// [design/tmr16_pkg.sv]
// Types shared by the 16-bit timer.
// Assumes nothing beyond the register header.
package tmr16_pkg;
    // Waveform family decoded from the 4-bit mode, Gray coded
    typedef enum logic [2:0] {
        TMR16_NORMAL = 3'h0,
        TMR16_CTC = 3'h1,
        TMR16_FAST = 3'h3,
        TMR16_PC = 3'h2,
        TMR16_PFC = 3'h6,
        TMR16_RSV = 3'h7
    } tmr16_kind_e;
    typedef logic [3:0] tmr16_wgm_t;
endpackage

// [design/tmr16_top.sv]
// 16-bit timer with waveform generation on two channels and input capture.
// Assumes a synchronous register port and pins already synchronous to I_CLK.
`timescale 1ns/1ps
`include "tmr16_regs.svh"

// Operation
// RQ1 - Phase-frequency mode loads compares at bottom
// RQ2 - Pin driven only when direction bit set
// RQ3 - Dual slope period is twice prescale times top
// RQ4 - Dual slope compare at bottom/top holds level
// RQ5 - Counter advances only on timer tick
// RQ6 - Control A field layout, reset zero
// RQ7 - Nonzero output mode overrides port function; 01 in PWM modes keeps port data except on channel A with mode bit 3 set
// RQ8 - Non-PWM modes: off, toggle, clear, set
// RQ9 - Fast PWM: clear/set on match, reverse at top
// RQ10 - Fast PWM compare equal top ignores match
// RQ11 - Dual slope: action by count direction
// RQ12 - Mode built from both control registers
// RQ13 - Normal and clear-on-match update immediately
// RQ14 - Phase correct: fixed or register top
// RQ15 - Fast PWM: top selection, update at top
// RQ16 - Phase-frequency: top from capture or compare
// RQ17 - Control B field layout, reset zero
// RQ18 - Filter needs four equal samples
// RQ19 - Edge select: zero falling, one rising
// RQ20 - Capture copies counter and sets flag
// RQ21 - Capture off when capture sets top
// RQ22 - Software prefers compare A as top
// RQ23 - Bottom is zero, dual slope up/down
// RQ24 - Clock select: stop, five dividers, external
// RQ25 - Match flag set on following tick
// RQ26 - Flags cleared by writing one
module tmr16_top
    import tmr16_pkg::*;
(
    input wire logic I_CLK, // Clock, 40 MHz
    input wire logic I_RSTN, // Synchronous reset, low
    input wire logic [3:0] I_ADDR, // Register word address
    input wire logic [15:0] I_WDATA, // Write data
    input wire logic I_WR, // Write strobe
    input wire logic I_RD, // Read strobe
    output logic [15:0] O_RDATA, // Read data, cycle after strobe
    input wire logic I_CAPTURE_PIN, // Capture input pin
    input wire logic I_EXT_CLK, // External count pin
    input wire logic [1:0] I_PORT_DATA, // Normal port data, bit0 = A
    output logic [1:0] O_PIN_OUT, // Pin level, bit0 = A
    output logic [1:0] O_PIN_OE // Pin drive enable, bit0 = A
);
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [15:0] count;
    logic dir;
    logic [15:0] cmp_buf [2];
    logic [15:0] cmp_act [2];
    logic [15:0] capture_value;
    logic [3:0] flags;
    logic [1:0] pin_dir;
    logic [9:0] pre;
    logic ext_q;
    logic cap_s;
    logic [3:0] cap_h;
    logic cap_f;
    logic cap_prev;
    logic [1:0] wave;
    logic [1:0] pend;

    // Register strobes
    wire wr_ca = I_WR && (I_ADDR == `TMR_A_CTRL_A);
    wire wr_cb = I_WR && (I_ADDR == `TMR_A_CTRL_B);
    wire wr_cnt = I_WR && (I_ADDR == `TMR_A_COUNT);
    wire wr_cma = I_WR && (I_ADDR == `TMR_A_CMP_A);
    wire wr_cmb = I_WR && (I_ADDR == `TMR_A_CMP_B);
    wire wr_cap = I_WR && (I_ADDR == `TMR_A_CAPTURE);
    wire wr_fl = I_WR && (I_ADDR == `TMR_A_FLAGS);
    wire wr_dir = I_WR && (I_ADDR == `TMR_A_PIN_DIR);

    // Mode decode
    wire [2:0] clock_select = ctrl_b[`TMR_CB_CS_HI:0];
    wire capture_filter_en = ctrl_b[`TMR_CB_FILT];
    wire capture_edge_sel = ctrl_b[`TMR_CB_EDGE];
    wire [1:0] wave_gen_mode_low = ctrl_a[1:0];
    wire [1:0] wave_gen_mode_high = ctrl_b[`TMR_CB_WGMH_HI:`TMR_CB_WGMH_LO];
    wire tmr16_wgm_t wave_gen_mode = {wave_gen_mode_high, wave_gen_mode_low}; // [RQ12]
    wire tmr16_kind_e kind =
        (wave_gen_mode == 4'h0) ? TMR16_NORMAL :
        (wave_gen_mode == 4'h4 || wave_gen_mode == 4'hC) ? TMR16_CTC :
        (wave_gen_mode == 4'h8 || wave_gen_mode == 4'h9) ? TMR16_PFC :
        (wave_gen_mode == 4'hD) ? TMR16_RSV :
        (wave_gen_mode[3:2] == 2'h0 || wave_gen_mode[3:1] == 3'h5) ? TMR16_PC :
        TMR16_FAST;
    // Capture register sets top in modes 8, 10, 12 and 14
    wire icr_top = wave_gen_mode[3] && !wave_gen_mode[0]; // [RQ21]
    wire [15:0] top_val = // [RQ13] [RQ14] [RQ15] [RQ16]
        (kind == TMR16_NORMAL || kind == TMR16_RSV) ? `TMR_MAX :
        icr_top ? capture_value :
        wave_gen_mode[3] || wave_gen_mode == 4'h4 ? cmp_act[0] :
        (wave_gen_mode[1:0] == 2'h1) ? `TMR_TOP8 :
        (wave_gen_mode[1:0] == 2'h2) ? `TMR_TOP9 : `TMR_TOP10;
    wire dual = (kind == TMR16_PC) || (kind == TMR16_PFC);
    wire at_top = (count == top_val);
    wire at_bot = (count == `TMR_BOTTOM); // [RQ23]

    // Prescaler taps; a 10-bit free count keeps all dividers in phase
    wire ext_fall = ext_q && !I_EXT_CLK;
    wire ext_rise = !ext_q && I_EXT_CLK;
    wire timer_tick = // [RQ24] [RQ3]
        (clock_select == 3'h1) ? 1'b1 :
        (clock_select == 3'h2) ? ((pre & `TMR_DIV8) == `TMR_DIV8) :
        (clock_select == 3'h3) ? ((pre & `TMR_DIV64) == `TMR_DIV64) :
        (clock_select == 3'h4) ? ((pre & `TMR_DIV256) == `TMR_DIV256) :
        (clock_select == 3'h5) ? (pre == `TMR_DIV1024) :
        (clock_select == 3'h6) ? ext_fall :
        (clock_select == 3'h7) ? ext_rise : 1'b0;

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            pre <= 10'h000;
            ext_q <= 1'b0;
        end else begin
            pre <= (clock_select == 3'h0) ? 10'h000 : pre + 10'h001;
            ext_q <= I_EXT_CLK;
        end
    end

    // Counter sequence; dual slope stays at top and bottom for one tick
    wire [15:0] cnt_inc = count + 16'h0001;
    wire [15:0] cnt_dec = count - 16'h0001;
    wire [15:0] next_count =
        !dual ? ((kind == TMR16_NORMAL || kind == TMR16_RSV) ? cnt_inc :
                 (at_top ? `TMR_BOTTOM : cnt_inc)) :
        dir ? (at_top ? cnt_dec : cnt_inc) :
        (at_bot ? cnt_inc : cnt_dec); // [RQ23]
    wire next_dir = !dual ? 1'b1 : dir ? !at_top : at_bot;

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            count <= `TMR_BOTTOM;
            dir <= 1'b1;
        end else if (wr_cnt) begin
            count <= I_WDATA;
        end else if (timer_tick) begin // [RQ5]
            count <= next_count;
            dir <= next_dir;
        end
    end

    // Compare update point: immediate, at top, or at bottom
    wire imm_upd = (kind == TMR16_NORMAL) || (kind == TMR16_CTC) || (kind == TMR16_RSV);
    wire buf_upd = imm_upd || (timer_tick && ((kind == TMR16_PFC) ? at_bot : at_top)); // [RQ1]

    // Overflow point per mode family
    wire ovf_set = timer_tick && (dual ? at_bot : // [RQ14] [RQ16]
        (kind == TMR16_FAST) ? at_top : (count == `TMR_MAX)); // [RQ13] [RQ15]

    // Capture filter and edge; pins are synchronous so one stage suffices
    wire cap_src = capture_filter_en ? cap_f : cap_s;
    wire cap_edge = capture_edge_sel ? (cap_src && !cap_prev) : (!cap_src && cap_prev); // [RQ19]
    wire cap_event = cap_edge && !icr_top; // [RQ21]

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            cap_s <= 1'b0;
            cap_h <= `TMR_FILT_ZERO;
            cap_f <= 1'b0;
            cap_prev <= 1'b0;
        end else begin
            cap_s <= I_CAPTURE_PIN;
            cap_h <= {cap_h[2:0], cap_s};
            if (cap_h == `TMR_FILT_ONES || cap_h == `TMR_FILT_ZERO) begin // [RQ18]
                cap_f <= cap_h[0];
            end
            cap_prev <= cap_src;
        end
    end

    // Capture register: hardware capture wins over software write
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            capture_value <= `TMR_BOTTOM;
        end else if (cap_event) begin
            capture_value <= count; // [RQ20]
        end else if (wr_cap) begin
            capture_value <= I_WDATA;
        end
    end

    // Per-channel compare, waveform and pin logic
    logic [1:0] match_set;
    logic [1:0] next_wave;
    logic [1:0] connected;
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            wire [1:0] out_mode = (ch == 0) ? ctrl_a[7:6] : ctrl_a[5:4];
            wire [15:0] cv = cmp_act[ch];
            wire hit = timer_tick && (count == cv);
            wire tog_ok = (ch == 0) && wave_gen_mode[3]; // Channel B 01 is reserved in the PWM modes
            wire non_pwm = (kind == TMR16_NORMAL) || (kind == TMR16_CTC);
            // Matches flag on the next tick, as the counter passed the value
            assign match_set[ch] = timer_tick && pend[ch]; // [RQ25]
            assign connected[ch] = (out_mode != 2'h0) && // [RQ7]
                (non_pwm || out_mode != 2'h1 || tog_ok); // [RQ9]
            assign next_wave[ch] =
                non_pwm ? (!hit ? wave[ch] : (out_mode == 2'h1) ? !wave[ch] : // [RQ8]
                    (out_mode == 2'h0) ? wave[ch] : out_mode[0]) :
                (out_mode == 2'h1) ? ((tog_ok && hit) ? !wave[ch] : wave[ch]) :
                (!out_mode[1] || !timer_tick || kind == TMR16_RSV) ? wave[ch] :
                (kind == TMR16_FAST) ? (at_top ? !out_mode[0] : // [RQ9] [RQ10]
                    hit ? out_mode[0] : wave[ch]) :
                (cv == `TMR_BOTTOM) ? out_mode[0] : // [RQ4]
                (cv == top_val) ? !out_mode[0] : // [RQ4]
                hit ? (dir ? out_mode[0] : !out_mode[0]) : wave[ch]; // [RQ11]

            always_ff @(posedge I_CLK) begin
                if (!I_RSTN) begin
                    cmp_buf[ch] <= `TMR_BOTTOM;
                    cmp_act[ch] <= `TMR_BOTTOM;
                    pend[ch] <= 1'b0;
                    wave[ch] <= 1'b0;
                    O_PIN_OUT[ch] <= 1'b0;
                    O_PIN_OE[ch] <= 1'b0;
                end else begin
                    if ((ch == 0) ? wr_cma : wr_cmb) begin
                        cmp_buf[ch] <= I_WDATA;
                    end
                    if (buf_upd) begin // [RQ1] [RQ13]
                        cmp_act[ch] <= cmp_buf[ch];
                    end
                    if (timer_tick) begin
                        pend[ch] <= hit;
                    end
                    wave[ch] <= next_wave[ch];
                    O_PIN_OUT[ch] <= connected[ch] ? next_wave[ch] : I_PORT_DATA[ch]; // [RQ7]
                    O_PIN_OE[ch] <= pin_dir[ch]; // [RQ2]
                end
            end
        end
    endgenerate

    // Flags: a set in the same cycle as a clear wins
    wire [3:0] flag_set = {cap_event, match_set[1], match_set[0], ovf_set};
    wire [3:0] flag_clr = wr_fl ? I_WDATA[3:0] : 4'h0;

    // Control, flag and direction registers
    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            ctrl_a <= 8'h00; // [RQ6]
            ctrl_b <= 8'h00; // [RQ17]
            flags <= 4'h0;
            pin_dir <= 2'h0;
        end else begin
            if (wr_ca) begin
                ctrl_a <= I_WDATA[7:0] & `TMR_CA_MASK; // [RQ6]
            end
            if (wr_cb) begin
                ctrl_b <= I_WDATA[7:0] & `TMR_CB_MASK; // [RQ17]
            end
            flags <= (flags & ~flag_clr) | flag_set; // [RQ26]
            if (wr_dir) begin
                pin_dir <= I_WDATA[1:0];
            end
        end
    end

    // Read select; unmapped addresses read zero
    wire [15:0] rd_mux =
        (I_ADDR == `TMR_A_CTRL_A) ? {8'h00, ctrl_a} :
        (I_ADDR == `TMR_A_CTRL_B) ? {8'h00, ctrl_b} :
        (I_ADDR == `TMR_A_COUNT) ? count :
        (I_ADDR == `TMR_A_CMP_A) ? cmp_buf[0] :
        (I_ADDR == `TMR_A_CMP_B) ? cmp_buf[1] :
        (I_ADDR == `TMR_A_CAPTURE) ? capture_value :
        (I_ADDR == `TMR_A_FLAGS) ? {12'h000, flags} :
        (I_ADDR == `TMR_A_PIN_DIR) ? {14'h0000, pin_dir} : 16'h0000;

    always_ff @(posedge I_CLK) begin
        if (!I_RSTN) begin
            O_RDATA <= 16'h0000;
        end else begin
            O_RDATA <= I_RD ? rd_mux : 16'h0000;
        end
    end

    // Checks on the timer behaviour
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    property p_cnt_hold;
        !timer_tick && !wr_cnt |=> $stable(count);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count moved without tick"); // [RQ5]

    property p_div8;
        // A stop written inside the span ends the spacing check rather than failing it
        (clock_select == 3'h2) && timer_tick && !wr_cb
            |=> !timer_tick [*7] ##1 (timer_tick || (clock_select != 3'h2));
    endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 spacing wrong"); // [RQ24]

    property p_oe_off;
        !pin_dir[0] |=> !O_PIN_OE[0];
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven with direction in"); // [RQ2]

    property p_match_flag;
        timer_tick && pend[0] |=> flags[`TMR_FL_MA];
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match flag not set"); // [RQ25]

    property p_capture;
        cap_event |=> (capture_value == $past(count)) && flags[`TMR_FL_CAP];
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost"); // [RQ20]

    property p_no_cap;
        icr_top && !wr_cap |=> $stable(capture_value);
    endproperty
    a_no_cap: assert property (p_no_cap) else $error("capture while top source"); // [RQ21]

    property p_pfc_upd;
        (kind == TMR16_PFC) && !(timer_tick && at_bot) && !wr_ca && !wr_cb
            |=> $stable(cmp_act[0]);
    endproperty
    a_pfc_upd: assert property (p_pfc_upd) else $error("compare loaded off bottom"); // [RQ1]

    // Channel B carries the duty tests, so the bottom case is watched there
    property p_dual_low;
        dual && (ctrl_a[5:4] == 2'h2) && (cmp_act[1] == `TMR_BOTTOM)
            && timer_tick && !wr_ca |=> !wave[1];
    endproperty
    a_dual_low: assert property (p_dual_low) else $error("bottom compare not low"); // [RQ4]

    property p_fast_ovf;
        (kind == TMR16_FAST) && timer_tick && at_top |=> flags[`TMR_FL_OVF];
    endproperty
    a_fast_ovf: assert property (p_fast_ovf) else $error("fast overflow missing"); // [RQ15]

    property p_flag_clr;
        wr_fl && I_WDATA[`TMR_FL_OVF] && !ovf_set |=> !flags[`TMR_FL_OVF];
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared"); // [RQ26]

    // Any dual-slope mode turns at top and steps down by one on the same tick
    property p_pc_turn;
        dual && timer_tick && dir && at_top && !at_bot && !wr_cnt
            |=> !dir ##0 (count == $past(count) - 16'h0001);
    endproperty
    a_pc_turn: assert property (p_pc_turn) else $error("dual slope turn wrong"); // [RQ23]

    c_capture: cover property (cap_event);
    c_fast_top: cover property ((kind == TMR16_FAST) && timer_tick && at_top);
    c_pfc_load: cover property ((kind == TMR16_PFC) && timer_tick && at_bot);
    c_toggle: cover property (connected[0] && (ctrl_a[7:6] == 2'h1) && $changed(wave[0]));
endmodule // tmr16_top

// [tb/tmr16_pins.sv]
// Model of the pins around the timer: capture source, count source, two pads.
// Assumes both pads carry a pull-up when the timer does not drive them.
`timescale 1ns/1ps
module tmr16_pins (
    input wire logic i_clk, // Bench clock
    input wire logic i_cap_lvl, // Level wanted on the capture line
    input wire logic i_ext_lvl, // Level wanted on the count line
    input wire logic i_clr, // Restart the high-time meter
    input wire logic [1:0] i_pin_out, // Timer pin levels
    input wire logic [1:0] i_pin_oe, // Timer drive enables
    output logic o_cap_pin, // Capture line to the timer
    output logic o_ext_pin, // Count line to the timer
    output logic [1:0] o_pad, // Resolved pad levels
    output logic [15:0] o_high_b // Cycles pad B was high since restart
);
    // Both sources are push-pull, so there is no floating level to model
    assign o_cap_pin = i_cap_lvl;
    assign o_ext_pin = i_ext_lvl;
    // An undriven pad reads high, so a lost enable cannot pass for a waveform
    assign o_pad = (i_pin_oe & i_pin_out) | ~i_pin_oe;
    // High-time meter on pad B, one sample per clock
    always_ff @(posedge i_clk) begin
        if (i_clr) begin
            o_high_b <= 16'h0000;
        end else begin
            o_high_b <= o_high_b + {15'h0000, o_pad[1]};
        end
    end
endmodule // tmr16_pins

// [tb/tb_tmr16_top.sv]
// Self-checking bench for the 16-bit timer: registers, prescaler, compare
// outputs, PWM duty and input capture. Assumes the register header is on the path.
`timescale 1ns/1ps
`include "tmr16_regs.svh"
module tb_tmr16_top;
    logic I_CLK = 1'b0;
    logic I_RSTN = 1'b0;
    logic [3:0] I_ADDR = 4'h0;
    logic [15:0] I_WDATA = 16'h0000;
    logic I_WR = 1'b0;
    logic I_RD = 1'b0;
    logic [1:0] I_PORT_DATA = 2'b01;
    logic [15:0] O_RDATA, high_b, v, w;
    logic [1:0] O_PIN_OUT, O_PIN_OE, pad;
    logic cap_lvl = 1'b1;
    logic ext_lvl = 1'b0;
    logic clr = 1'b0;
    logic cap_pin, ext_pin;
    int n_mismatch = 0;
    int check_count = 0;
    int i;
    int dv[5] = '{1, 8, 64, 256, 1024};

    tmr16_top u_dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CAPTURE_PIN(cap_pin),
        .I_EXT_CLK(ext_pin), .I_PORT_DATA(I_PORT_DATA), .O_PIN_OUT(O_PIN_OUT),
        .O_PIN_OE(O_PIN_OE));
    tmr16_pins u_pins (.i_clk(I_CLK), .i_cap_lvl(cap_lvl), .i_ext_lvl(ext_lvl), .i_clr(clr),
        .i_pin_out(O_PIN_OUT), .i_pin_oe(O_PIN_OE), .o_cap_pin(cap_pin),
        .o_ext_pin(ext_pin), .o_pad(pad), .o_high_b(high_b));

    // 40 MHz clock
    initial begin
        forever #12.5 I_CLK = ~I_CLK;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge I_CLK);
    endtask

    // One-cycle write strobe; the gap cycle keeps strobes from merging
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge I_CLK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge I_CLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1;
        d = O_RDATA;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: saw %h, wanted %h", $time, what, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Normal mode, one compare match at 5 while the counter runs past it
    task automatic act(input logic [1:0] om, input logic e);
        wr(`TMR_A_CTRL_B, 16'h0000);
        wr(`TMR_A_CTRL_A, {8'h00, om, 6'h00});
        wr(`TMR_A_CMP_A, 16'h0005);
        wr(`TMR_A_COUNT, 16'h0000);
        wr(`TMR_A_FLAGS, 16'h000F);
        wr(`TMR_A_CTRL_B, 16'h0001);
        cyc(10);
        wr(`TMR_A_CTRL_B, 16'h0000);
        cyc(2);
        chk({15'h0000, O_PIN_OUT[0]}, {15'h0000, e}, "match action");
        rd(`TMR_A_FLAGS, v);
        chk({15'h0000, v[1]}, 16'h0001, "match flag");
    endtask

    // Stopped counter, pin driven to lvl for hold plus one cycles then to fin, then the capture flag and value
    task automatic cap(input logic [15:0] cb, input logic lvl, input int hold,
                       input logic fin, input logic ef, input logic [15:0] cnt);
        wr(`TMR_A_CTRL_B, cb);
        wr(`TMR_A_COUNT, cnt);
        wr(`TMR_A_FLAGS, 16'h000F);
        @(posedge I_CLK);
        cap_lvl <= lvl;
        cyc(hold);
        @(posedge I_CLK);
        cap_lvl <= fin;
        cyc(12);
        rd(`TMR_A_FLAGS, v);
        chk({15'h0000, v[3]}, {15'h0000, ef}, "capture flag");
        if (ef) begin
            rd(`TMR_A_CAPTURE, v);
            chk(v, cnt, "capture value");
        end
    endtask

    // Channel B duty over 200 cycles, a whole number of periods
    task automatic pwm(input logic [3:0] m, input logic [15:0] top, input logic [15:0] cmp,
                       input logic [1:0] om, input logic [15:0] e);
        wr(`TMR_A_CTRL_B, 16'h0000);
        wr(`TMR_A_CTRL_A, {8'h00, 2'b00, om, 2'b00, m[1:0]});
        wr(`TMR_A_CMP_A, top);
        wr(`TMR_A_CMP_B, cmp);
        wr(`TMR_A_COUNT, 16'h0000);
        wr(`TMR_A_CTRL_B, {8'h00, 3'b000, m[3:2], 3'b001});
        cyc(60);
        @(posedge I_CLK);
        clr <= 1'b1;
        @(posedge I_CLK);
        clr <= 1'b0;
        cyc(200);
        #1;
        chk(high_b, e, "pad B high time");
    endtask

    // Hang guard
    initial begin
        #750000;
        n_mismatch++;
        $display("[FAIL] %0t run did not finish", $time);
        test_done;
    end

    initial begin
        cyc(12);
        I_RSTN <= 1'b1;
        rd(`TMR_A_CTRL_A, v);
        chk(v, 16'h0000, "ctrl a reset");
        rd(`TMR_A_CTRL_B, v);
        chk(v, 16'h0000, "ctrl b reset");
        chk({14'h0000, O_PIN_OE}, 16'h0000, "enable at reset");
        wr(`TMR_A_CTRL_A, 16'hFFFF);
        rd(`TMR_A_CTRL_A, v);
        chk(v, 16'h00F3, "ctrl a bits");
        wr(`TMR_A_CTRL_B, 16'h00FF);
        rd(`TMR_A_CTRL_B, v);
        chk(v, 16'h00DF, "ctrl b bits");
        wr(`TMR_A_CTRL_B, 16'h0000);
        wr(`TMR_A_CTRL_A, 16'h0000);
        wr(4'h9, 16'hFFFF);
        rd(4'h9, v);
        chk(v, 16'h0000, "unmapped");
        cyc(2);
        chk({14'h0000, O_PIN_OUT}, 16'h0001, "port data");
        $display("test registers done");
        act(2'b11, 1'b1);
        act(2'b10, 1'b0);
        act(2'b01, 1'b1);
        act(2'b01, 1'b0);
        wr(`TMR_A_FLAGS, 16'h0002);
        rd(`TMR_A_FLAGS, v);
        chk({15'h0000, v[1]}, 16'h0000, "flag clear");
        $display("test compare actions done");
        // Four prescaled ticks each; the slack covers the write cycles
        for (i = 0; i < 5; i++) begin
            wr(`TMR_A_CTRL_B, 16'h0000);
            wr(`TMR_A_COUNT, 16'h0000);
            wr(`TMR_A_CTRL_B, 16'(i + 1));
            cyc(4 * dv[i]);
            wr(`TMR_A_CTRL_B, 16'h0000);
            rd(`TMR_A_COUNT, v);
            chk({15'h0000, (v >= 16'h0004 && v <= 16'h0007)}, 16'h0001, "prescale");
        end
        cyc(20);
        rd(`TMR_A_COUNT, w);
        chk(w, v, "stopped count");
        for (i = 6; i < 8; i++) begin
            wr(`TMR_A_CTRL_B, 16'h0000);
            wr(`TMR_A_COUNT, 16'h0000);
            wr(`TMR_A_CTRL_B, 16'(i));
            repeat (3) begin
                @(posedge I_CLK);
                ext_lvl <= 1'b1;
                cyc(3);
                @(posedge I_CLK);
                ext_lvl <= 1'b0;
                cyc(3);
            end
            wr(`TMR_A_CTRL_B, 16'h0000);
            rd(`TMR_A_COUNT, v);
            chk(v, 16'h0003, "external count");
        end
        $display("test clock select done");
        cap(16'h0000, 1'b0, 8, 1'b0, 1'b1, 16'h1234);
        cap(16'h0000, 1'b1, 8, 1'b1, 1'b0, 16'h1235);
        cap(16'h0040, 1'b0, 8, 1'b0, 1'b0, 16'h1236);
        cap(16'h0040, 1'b1, 8, 1'b1, 1'b1, 16'h1237);
        cap(16'h00C0, 1'b0, 1, 1'b1, 1'b0, 16'h1238);
        cap(16'h00C0, 1'b0, 8, 1'b1, 1'b1, 16'h1239);
        cap(16'h0058, 1'b0, 8, 1'b1, 1'b0, 16'h123A);
        $display("test capture done");
        wr(`TMR_A_PIN_DIR, 16'h0003);
        cyc(2);
        chk({14'h0000, O_PIN_OE}, 16'h0003, "drive enable");
        // Compare A sets TOP, so the period may be changed safely at run time
        pwm(4'hF, 16'h0009, 16'h0003, 2'b10, 16'h0050);
        pwm(4'hF, 16'h0009, 16'h0003, 2'b11, 16'h0078);
        pwm(4'hF, 16'h0009, 16'h0009, 2'b10, 16'h00C8);
        pwm(4'hF, 16'h0009, 16'h0009, 2'b11, 16'h0000);
        pwm(4'hF, 16'h0009, 16'h0003, 2'b01, 16'h0000);
        pwm(4'h9, 16'h000A, 16'h0004, 2'b10, 16'h0050);
        pwm(4'h9, 16'h000A, 16'h0004, 2'b11, 16'h0078);
        pwm(4'h9, 16'h000A, 16'h0000, 2'b10, 16'h0000);
        pwm(4'h9, 16'h000A, 16'h000A, 2'b10, 16'h00C8);
        pwm(4'h9, 16'h000A, 16'h0000, 2'b11, 16'h00C8);
        pwm(4'hB, 16'h000A, 16'h0004, 2'b10, 16'h0050);
        pwm(4'hB, 16'h000A, 16'h000A, 2'b11, 16'h0000);
        // Capture register sets TOP of 9, compare A holds an unrelated value
        wr(`TMR_A_CAPTURE, 16'h0009);
        pwm(4'hE, 16'h0005, 16'h0003, 2'b10, 16'h0050);
        wr(`TMR_A_PIN_DIR, 16'h0001);
        pwm(4'hF, 16'h0009, 16'h0003, 2'b10, 16'h00C8);
        $display("test waveforms done");
        test_done;
    end
endmodule // tb_tmr16_top
